// *** sim/tb_upe_protocol_engine.sv ***
// Self-checking testbench for the protocol engine
`timescale 1ns/1ps
`default_nettype none
module tb_upe_protocol_engine;
  logic clk = 1'b0, rst = 1'b1, oe, dir, nxt, stp, reg_wr, rx_ready, tx_start, tx_stuff, tx_nrzi, tx_valid, tx_end;
  logic [7:0] din, dout, reg_wdata, reg_rdata, tx_data, st, rxa, rxb, txa, txb, q;
  logic [5:0] reg_addr, tx_sync, tx_eop, sync_c, eop_c;
  logic [3:0] tx_pid, pid_c;
  logic [1:0] ls = 2'h0, opmode = 2'h0, stuff_c;
  logic se = 1'b1, sv = 1'b0, vv = 1'b0, id = 1'b1, hd = 1'b0, ra = 1'b0, re = 1'b0, rxv = 1'b0;
  logic hs = 1'b0, dp = 1'b0, dm = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic [7:0] regs [64] = '{default: 8'h00};
  logic [8:0] stab [8] = '{9'h0c8, 9'h088, 9'h0a8, 9'h0b8, 9'h0b0, 9'h130, 9'h131, 9'h030};
  logic [8:0] ttab [5] = '{9'h1c5, 9'h185, 9'h0c5, 9'h1c3, 9'h120};
  int n_fail = 0, total_checks = 0, cyc = 0, n_st = 0, k = 0;
  always #50 clk = ~clk;
  assign reg_rdata = regs[reg_addr];
  upe_protocol_engine upe_protocol_engine_inst (.CLK_IN(clk), .RST_IN(rst), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_OUT(oe), .DIR_OUT(dir), .NXT_OUT(nxt), .STP_IN(stp), .REG_WR_OUT(reg_wr), .REG_ADDR_OUT(reg_addr),
    .REG_WDATA_OUT(reg_wdata), .REG_RDATA_IN(reg_rdata), .LINE_STATE_IN(ls), .SESS_END_IN(se), .SESS_VALID_IN(sv),
    .VBUS_VALID_IN(vv), .ID_IN(id), .HOST_DISC_IN(hd), .RX_ACTIVE_IN(ra), .RX_ERROR_IN(re), .RX_VALID_IN(rxv),
    .RX_DATA_IN(rxd), .RX_READY_OUT(rx_ready), .HS_MODE_IN(hs), .OPMODE_IN(opmode), .DP_PULLDOWN_IN(dp),
    .DM_PULLDOWN_IN(dm), .TX_START_OUT(tx_start), .TX_PID_OUT(tx_pid), .TX_SYNC_BITS_OUT(tx_sync),
    .TX_STUFF_EN_OUT(tx_stuff), .TX_NRZI_EN_OUT(tx_nrzi), .TX_VALID_OUT(tx_valid), .TX_DATA_OUT(tx_data),
    .TX_READY_IN(1'b1), .TX_END_OUT(tx_end), .TX_EOP_BITS_OUT(tx_eop), .TX_BUSY_IN(1'b0));
  upe_link_model upe_link_model_inst (.clk_in(clk), .dir_in(dir), .nxt_in(nxt), .dev_data_in(dout),
    .data_out(din), .stp_out(stp));
  // Register file and snapshots of what the device hands out
  always @(posedge clk)
  begin
    if (reg_wr) regs[reg_addr] <= reg_wdata;
    if (dir && oe && !nxt) {st, n_st} <= {dout, n_st + 1};
    if (dir && oe && nxt) {rxa, rxb} <= {rxb, dout};
    if (tx_start) {sync_c, stuff_c, pid_c} <= {tx_sync, tx_stuff, tx_nrzi, tx_pid};
    if (tx_valid) {txa, txb} <= {txb, tx_data};
    if (tx_end) eop_c <= tx_eop;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // Status byte as the encoding tables define it
  function automatic logic [7:0] exp_st();
    logic [1:0] v, r;
    v = vv ? 2'h3 : sv ? 2'h2 : se ? 2'h0 : 2'h1;
    r = hd ? 2'h2 : !ra ? 2'h0 : re ? 2'h3 : 2'h1;
    return {1'b0, id, r, v, ls};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrdy();
    do @(posedge clk); while (rx_ready !== 1'b1 && cyc < 20000);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    step(12);
    // Reset values are looked at while reset still holds
    chk("reset", {dir, nxt, oe, reg_wr, tx_start, tx_valid, tx_stuff, tx_nrzi}, 8'h03);
    rst = 1'b0;
    step(6);
    chk("reset status", st, exp_st());
    $display("test reset done");
    // Back-to-back writes, including both address extremes, then reads
    upe_link_model_inst.wr(6'h00, 8'ha5);
    upe_link_model_inst.wr(6'h3f, 8'hff);
    upe_link_model_inst.rd(6'h00, q);
    chk("reg 00", q, 8'ha5);
    upe_link_model_inst.rd(6'h3f, q);
    chk("reg 3f", q, 8'hff);
    $display("test registers done");
    // Walk every comparator and line codes 0 to 2 through the status byte
    for (int i = 0; i < 8; i++)
    begin
      {ls, se, sv, vv, id, ra, re, hd} = stab[i];
      step(8);
      chk("status", st, exp_st());
    end
    $display("test status done");
    ra = 1'b1;
    step(8);
    chk("rx active", st, exp_st());
    rxv = 1'b1;
    rxd = 8'h3c;
    wrdy();
    #1 rxd = 8'hc3;
    wrdy();
    #1 rxv = 1'b0;
    step(6);
    chk("rx byte", rxb, 8'hc3);
    chk("rx byte 0", rxa, 8'h3c);
    re = 1'b1;
    step(8);
    chk("rx error", st, exp_st());
    {ra, re} = 2'h0;
    step(8);
    chk("rx end", st, exp_st());
    $display("test receive done");
    for (int i = 0; i < 5; i++)
    begin
      {hs, dp, dm, opmode} = ttab[i][8:4];
      k = n_st;
      upe_link_model_inst.tx(ttab[i][3:0], 8'h12, 8'h80 | i[7:0]);
      step(10);
      chk("pid", {4'h0, pid_c}, {4'h0, ttab[i][3:0]});
      chk("sync", {2'h0, sync_c}, hs ? 8'h20 : 8'h08);
      chk("stuff", {6'h00, stuff_c}, opmode == upe_pkg::UPE_OPMODE_CHIRP ? 8'h00 : 8'h03);
      chk("tx byte", txb, 8'h80 | i[7:0]);
      chk("tx byte 0", txa, 8'h12);
      chk("tx status sent", {7'h00, n_st != k}, 8'h01);
      chk("eop", {2'h0, eop_c}, (hs && dp && dm && ttab[i][3:0] == upe_pkg::UPE_PID_SOF) ? 8'h28 : 8'h08);
      chk("tx status", st, exp_st());
    end
    $display("test transmit done");
    complete_run();
  end
endmodule
`default_nettype wire

// *** sim/upe_link_model.sv ***
// Behavioural link controller on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module upe_link_model (
  input wire logic clk_in,
  input wire logic dir_in,
  input wire logic nxt_in,
  input wire logic [7:0] dev_data_in,
  output logic [7:0] data_out,
  output var logic stp_out = 1'b0
);
  logic [7:0] drv_ff = 8'h00;
  // Released bus shows the inverse so a stale byte never looks valid
  assign data_out = dir_in ? ~drv_ff : drv_ff;
  // Wait for an edge that samples the throttle high; timeout guards a hang
  task automatic wnxt();
    int i;
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (!nxt_in && i < 20);
  endtask
  // Commands only start while the device leaves the bus to us
  task automatic cmd(input logic [7:0] c);
    @(posedge clk_in);
    #1;
    // Direction is judged after the edge settles, so a fresh turnaround is seen
    while (dir_in)
    begin
      @(posedge clk_in);
      #1;
    end
    drv_ff = c;
    wnxt();
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cmd({2'h2, a});
    #1 drv_ff = d;
    @(posedge clk_in);
    #1 drv_ff = 8'h00;
    stp_out = 1'b1;
    @(posedge clk_in);
    #1 stp_out = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    cmd({2'h3, a});
    #1 drv_ff = 8'h00;
    @(posedge clk_in);
    @(posedge clk_in);
    q = dev_data_in;
    #1;
  endtask
  task automatic tx(input logic [3:0] pid, input logic [7:0] b0, input logic [7:0] b1);
    cmd({4'h4, pid});
    #1 drv_ff = b0;
    wnxt();
    #1 drv_ff = b1;
    wnxt();
    #1 drv_ff = 8'h00;
    stp_out = 1'b1;
    @(posedge clk_in);
    #1 stp_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/upe_protocol_engine_properties.sv ***
// Port checker for the protocol engine, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module upe_checker
  import upe_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE_OUT,
  input wire logic DIR_OUT,
  input wire logic NXT_OUT,
  input wire logic STP_IN,
  input wire logic REG_WR_OUT,
  input wire logic [7:0] REG_RDATA_IN,
  input wire logic [1:0] LINE_STATE_IN,
  input wire logic ID_IN,
  input wire logic HS_MODE_IN,
  input wire logic [1:0] OPMODE_IN,
  input wire logic DP_PULLDOWN_IN,
  input wire logic DM_PULLDOWN_IN,
  input wire logic TX_START_OUT,
  input wire logic [3:0] TX_PID_OUT,
  input wire logic [5:0] TX_SYNC_BITS_OUT,
  input wire logic TX_STUFF_EN_OUT,
  input wire logic TX_NRZI_EN_OUT,
  input wire logic TX_VALID_OUT,
  input wire logic TX_END_OUT,
  input wire logic [5:0] TX_EOP_BITS_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // Fresh commands only count after an idle bus, since leftovers are refused
  property p_wr_take;
    !DIR_OUT && !NXT_OUT && $past(DATA_IN) == UPE_IDLE && DATA_IN[7:6] == UPE_CMD_REG_WRITE |=> NXT_OUT;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write command not throttled in");
  property p_wr_stop;
    NXT_OUT && STP_IN && !DIR_OUT |=> !NXT_OUT;
  endproperty
  a_wr_stop: assert property (p_wr_stop) else $error("throttle held after stop");
  property p_wr_commit;
    REG_WR_OUT |-> !DIR_OUT && $past(STP_IN) == 1'b0 && $past(STP_IN, 2) == 1'b1;
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("register commit out of place");
  property p_rd;
    !DIR_OUT && !NXT_OUT && $past(DATA_IN) == UPE_IDLE && DATA_IN[7:6] == UPE_CMD_REG_READ
    |=> NXT_OUT ##1 (DIR_OUT && !NXT_OUT) ##1 (DIR_OUT && DATA_OE_OUT && DATA_OUT == REG_RDATA_IN) ##1 !DIR_OUT;
  endproperty
  a_rd: assert property (p_rd) else $error("register read sequence wrong");
  property p_ls;
    $changed(LINE_STATE_IN) && !DIR_OUT && !NXT_OUT && !STP_IN |-> ##[1:4] DIR_OUT;
  endproperty
  a_ls: assert property (p_ls) else $error("no status after line change");
  property p_id;
    $changed(ID_IN) && !DIR_OUT && !NXT_OUT |-> ##[1:4] DIR_OUT;
  endproperty
  a_id: assert property (p_id) else $error("no status after comparator change");
  property p_tx_quiet;
    TX_VALID_OUT |-> !DIR_OUT;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("bus turned during transmit");
  property p_sync;
    TX_START_OUT |-> TX_SYNC_BITS_OUT == (HS_MODE_IN ? 6'h20 : 6'h08);
  endproperty
  a_sync: assert property (p_sync) else $error("sync length wrong");
  property p_chirp;
    TX_START_OUT |-> TX_STUFF_EN_OUT == (OPMODE_IN != UPE_OPMODE_CHIRP) && TX_NRZI_EN_OUT == TX_STUFF_EN_OUT;
  endproperty
  a_chirp: assert property (p_chirp) else $error("stuffing not matched to mode");
  property p_eop;
    TX_END_OUT |-> TX_EOP_BITS_OUT == ((HS_MODE_IN && DP_PULLDOWN_IN && DM_PULLDOWN_IN
                                       && TX_PID_OUT == UPE_PID_SOF) ? 6'h28 : 6'h08);
  endproperty
  a_eop: assert property (p_eop) else $error("end of packet length wrong");
endmodule
bind upe_protocol_engine upe_checker upe_checker_inst (.*);
`default_nettype wire

// *** verilog/upe_pkg.sv ***
// Package with ULPI command encodings, status byte fields and transmitter constants
package upe_pkg;
  localparam logic [1:0] UPE_CMD_SPECIAL = 2'h0;
  localparam logic [1:0] UPE_CMD_TRANSMIT = 2'h1;
  localparam logic [1:0] UPE_CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] UPE_CMD_REG_READ = 2'h3;
  localparam logic [7:0] UPE_IDLE = 8'h00;
  localparam int UPE_CMD_HI = 7;
  localparam int UPE_CMD_LO = 6;
  localparam int UPE_ADDR_HI = 5;
  localparam int UPE_PID_HI = 3;
  localparam logic [3:0] UPE_PID_SOF = 4'h5;
  localparam logic [1:0] UPE_OPMODE_CHIRP = 2'h2;
  localparam logic [1:0] UPE_VB_BELOW_END = 2'h0;
  localparam logic [1:0] UPE_VB_BETWEEN = 2'h1;
  localparam logic [1:0] UPE_VB_SESS = 2'h2;
  localparam logic [1:0] UPE_VB_VALID = 2'h3;
  localparam logic [1:0] UPE_RX_NONE = 2'h0;
  localparam logic [1:0] UPE_RX_ACTIVE = 2'h1;
  localparam logic [1:0] UPE_RX_ERROR = 2'h3;
  localparam logic [1:0] UPE_RX_HOSTDISC = 2'h2;
  localparam logic UPE_STATUS_RSVD = 1'b0;
  localparam int UPE_HS_SYNC_BITS = 32;
  localparam int UPE_FLS_SYNC_BITS = 8;
  localparam int UPE_LONG_EOP_BITS = 40;
  localparam int UPE_EOP_BITS = 8;
  localparam int UPE_ADDR_W = 6;
  typedef enum logic [2:0] {
    UPE_S_IDLE, UPE_S_WR_DATA, UPE_S_WR_STOP, UPE_S_RD_TURN,
    UPE_S_RD_DATA, UPE_S_RD_BACK, UPE_S_TX, UPE_S_RX
  } upe_state_t;
endpackage

// *** verilog/upe_protocol_engine.sv ***
// ULPI PHY-side protocol engine: register access, status bytes, transmit framing
// Functional notes
// - Device raises NXT on write command; link puts data next edge.
// - Link gives idle and STP; device latches data and drops NXT.
// - DIR stays low through write; value committed after STP falls.
// - Device takes read command with NXT, then raises DIR, drops NXT.
// - After turnaround device drives register value one cycle, then lowers DIR.
// - Status byte sent at once on line state change while DIR low.
// - VBUS or ID comparator change sends a status byte.
// - During receive: status with NXT low, data with NXT high.
// - During transmit, status bytes only after link's STP.
// - Status bits one and zero carry line state.
// - Status bits three, two encode VBUS level.
// - Status bits five, four encode receive events.
// - Status bit six carries ID pin level.
// - Sync is 32 bits for high speed, 8 bits otherwise.
// - Chirp opmode turns off bit stuffing and NRZI.
// - High-speed host appends 40-bit EOP after SOF PID.
// - Long EOP only with both pulldowns set; never in device mode.
// - Transmit ends on STP with NXT high; STP never with NXT low.
`timescale 1ns/1ps
`default_nettype none
module upe_protocol_engine
  import upe_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // ULPI bus
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_OUT,
  output logic DIR_OUT,
  output logic NXT_OUT,
  input wire logic STP_IN,
  // Register file side
  output logic REG_WR_OUT,
  output logic [5:0] REG_ADDR_OUT,
  output logic [7:0] REG_WDATA_OUT,
  input wire logic [7:0] REG_RDATA_IN,
  // Analog status
  input wire logic [1:0] LINE_STATE_IN,
  input wire logic SESS_END_IN,
  input wire logic SESS_VALID_IN,
  input wire logic VBUS_VALID_IN,
  input wire logic ID_IN,
  input wire logic HOST_DISC_IN,
  // Receiver stream
  input wire logic RX_ACTIVE_IN,
  input wire logic RX_ERROR_IN,
  input wire logic RX_VALID_IN,
  input wire logic [7:0] RX_DATA_IN,
  output logic RX_READY_OUT,
  // Transmitter configuration
  input wire logic HS_MODE_IN,
  input wire logic [1:0] OPMODE_IN,
  input wire logic DP_PULLDOWN_IN,
  input wire logic DM_PULLDOWN_IN,
  // Transmitter stream
  output logic TX_START_OUT,
  output logic [3:0] TX_PID_OUT,
  output logic [5:0] TX_SYNC_BITS_OUT,
  output logic TX_STUFF_EN_OUT,
  output logic TX_NRZI_EN_OUT,
  output logic TX_VALID_OUT,
  output logic [7:0] TX_DATA_OUT,
  input wire logic TX_READY_IN,
  output logic TX_END_OUT,
  output logic [5:0] TX_EOP_BITS_OUT,
  input wire logic TX_BUSY_IN
);
  upe_state_t state_ff;
  upe_state_t nxt_state;
  logic [7:0] status;
  logic [7:0] last_status_ff;
  logic status_change;
  logic [5:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rd_ff;
  logic [3:0] pid_ff;
  logic pend_status_ff;
  logic rxb_valid;
  logic [7:0] rxb_data;
  logic rxb_pop;
  logic rx_in_ready;
  logic rx_push;
  logic [1:0] cmd;

  // While we own the bus the link is not driving, so decode must see idle
  assign cmd = DIR_OUT ? UPE_CMD_SPECIAL : DATA_IN[UPE_CMD_HI:UPE_CMD_LO];

  upe_status_enc u_enc (
    .line_state_in(LINE_STATE_IN),
    .sess_end_in(SESS_END_IN),
    .sess_valid_in(SESS_VALID_IN),
    .vbus_valid_in(VBUS_VALID_IN),
    .rx_active_in(RX_ACTIVE_IN),
    .rx_error_in(RX_ERROR_IN),
    .host_disc_in(HOST_DISC_IN),
    .id_in(ID_IN),
    .status_out(status)
  );

  // Buffer absorbs receive bytes while the bus is busy with status
  upe_skid_buf #(.WIDTH(8)) u_rxbuf (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .in_valid_in(rx_push),
    .in_ready_out(rx_in_ready),
    .in_data_in(RX_DATA_IN),
    .out_valid_out(rxb_valid),
    .out_ready_in(rxb_pop),
    .out_data_out(rxb_data)
  );

  // Any field change, line, VBUS, ID or event, needs a fresh status byte
  assign status_change = (status != last_status_ff);

  // Receive bytes leave the buffer only in data cycles
  assign rxb_pop = (state_ff == UPE_S_RX) && rxb_valid && !pend_status_ff;

  // Source only hands over when it saw our registered ready
  assign rx_push = RX_VALID_IN && RX_READY_OUT;

  // Command decode and sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      UPE_S_IDLE:
      begin
        if (RX_ACTIVE_IN)
          nxt_state = UPE_S_RX;
        else if (cmd == UPE_CMD_REG_WRITE)
          nxt_state = UPE_S_WR_DATA;
        else if (cmd == UPE_CMD_REG_READ)
          nxt_state = UPE_S_RD_TURN;
        else if (cmd == UPE_CMD_TRANSMIT)
          nxt_state = UPE_S_TX;
      end
      UPE_S_WR_DATA:
        if (STP_IN)
          nxt_state = UPE_S_WR_STOP;
      UPE_S_WR_STOP:
        nxt_state = UPE_S_IDLE;
      UPE_S_RD_TURN:
        nxt_state = UPE_S_RD_DATA;
      UPE_S_RD_DATA:
        nxt_state = UPE_S_RD_BACK;
      UPE_S_RD_BACK:
        nxt_state = UPE_S_IDLE;
      UPE_S_TX:
        if (STP_IN && NXT_OUT)
          nxt_state = UPE_S_IDLE;
      UPE_S_RX:
        if (!RX_ACTIVE_IN && !rxb_valid && !pend_status_ff)
          nxt_state = UPE_S_IDLE;
      default:
        nxt_state = UPE_S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      state_ff <= UPE_S_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Command capture
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      addr_ff <= 6'h00;
      wdata_ff <= 8'h00;
      pid_ff <= 4'h0;
      rd_ff <= 8'h00;
    end
    else
    begin
      if (state_ff == UPE_S_IDLE && cmd != UPE_CMD_SPECIAL)
      begin
        addr_ff <= DATA_IN[UPE_ADDR_HI:0];
        pid_ff <= DATA_IN[UPE_PID_HI:0];
      end
      if (state_ff == UPE_S_WR_DATA && !STP_IN)
        wdata_ff <= DATA_IN;
      if (state_ff == UPE_S_RD_TURN)
        rd_ff <= REG_RDATA_IN;
    end
  end

  // Register-file strobe lands when STP has dropped
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      REG_WR_OUT <= 1'b0;
      REG_ADDR_OUT <= 6'h00;
      REG_WDATA_OUT <= 8'h00;
    end
    else
    begin
      REG_WR_OUT <= (state_ff == UPE_S_WR_STOP) && !STP_IN;
      REG_ADDR_OUT <= (state_ff == UPE_S_IDLE) ? DATA_IN[UPE_ADDR_HI:0] : addr_ff;
      REG_WDATA_OUT <= wdata_ff;
    end
  end

  // Status pending: hardware set beats the clear when sent
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      pend_status_ff <= 1'b0;
      last_status_ff <= 8'h00;
    end
    else
    begin
      last_status_ff <= status;
      if (status_change)
        pend_status_ff <= 1'b1;
      else if (state_ff == UPE_S_TX && nxt_state == UPE_S_IDLE)
        pend_status_ff <= 1'b1;
      else if (DIR_OUT && !NXT_OUT && DATA_OE_OUT && (state_ff == UPE_S_IDLE || state_ff == UPE_S_RX))
        pend_status_ff <= 1'b0;
    end
  end

  // Bus drive: DIR, NXT and DATA; a status byte only goes out with the bus owned
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      DIR_OUT <= 1'b0;
      NXT_OUT <= 1'b0;
      DATA_OUT <= 8'h00;
      DATA_OE_OUT <= 1'b0;
    end
    else
    begin
      DIR_OUT <= 1'b0;
      NXT_OUT <= 1'b0;
      DATA_OE_OUT <= 1'b0;
      DATA_OUT <= UPE_IDLE;
      case (nxt_state)
        UPE_S_WR_DATA, UPE_S_WR_STOP:
          NXT_OUT <= (nxt_state == UPE_S_WR_DATA);
        UPE_S_RD_TURN:
          NXT_OUT <= 1'b1;
        UPE_S_RD_DATA:
          DIR_OUT <= 1'b1;
        UPE_S_RD_BACK:
        begin
          DIR_OUT <= 1'b1;
          DATA_OE_OUT <= 1'b1;
          DATA_OUT <= rd_ff;
        end
        UPE_S_TX:
          NXT_OUT <= TX_READY_IN;
        UPE_S_RX:
        begin
          DIR_OUT <= 1'b1;
          DATA_OE_OUT <= DIR_OUT;
          if (pend_status_ff || !rxb_valid)
            DATA_OUT <= status;
          else
          begin
            NXT_OUT <= DIR_OUT;
            DATA_OUT <= rxb_data;
          end
        end
        UPE_S_IDLE:
          if (state_ff == UPE_S_IDLE && (pend_status_ff || status_change) && cmd == UPE_CMD_SPECIAL)
          begin
            DIR_OUT <= 1'b1;
            DATA_OE_OUT <= DIR_OUT;
            DATA_OUT <= status;
          end
        default:
          DIR_OUT <= 1'b0;
      endcase
    end
  end

  // Ready is registered, so it drops after an unpopped push; costs rate, never a byte
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      RX_READY_OUT <= 1'b0;
    else
      RX_READY_OUT <= rx_in_ready && !(rx_push && !rxb_pop);
  end

  // Transmitter framing, chirp and long EOP
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      TX_START_OUT <= 1'b0;
      TX_PID_OUT <= 4'h0;
      TX_SYNC_BITS_OUT <= 6'h00;
      TX_STUFF_EN_OUT <= 1'b1;
      TX_NRZI_EN_OUT <= 1'b1;
      TX_VALID_OUT <= 1'b0;
      TX_DATA_OUT <= 8'h00;
      TX_END_OUT <= 1'b0;
      TX_EOP_BITS_OUT <= 6'h00;
    end
    else
    begin
      TX_START_OUT <= (state_ff == UPE_S_IDLE) && (nxt_state == UPE_S_TX);
      if (state_ff == UPE_S_IDLE && nxt_state == UPE_S_TX)
        TX_PID_OUT <= DATA_IN[UPE_PID_HI:0];
      TX_SYNC_BITS_OUT <= HS_MODE_IN ? 6'(UPE_HS_SYNC_BITS) : 6'(UPE_FLS_SYNC_BITS);
      TX_STUFF_EN_OUT <= (OPMODE_IN != UPE_OPMODE_CHIRP);
      TX_NRZI_EN_OUT <= (OPMODE_IN != UPE_OPMODE_CHIRP);
      TX_VALID_OUT <= (state_ff == UPE_S_TX) && NXT_OUT && !STP_IN && !TX_START_OUT; // Command cycle is no payload
      TX_DATA_OUT <= DATA_IN;
      TX_END_OUT <= (state_ff == UPE_S_TX) && STP_IN && NXT_OUT;
      if (HS_MODE_IN && DP_PULLDOWN_IN && DM_PULLDOWN_IN && pid_ff == UPE_PID_SOF)
        TX_EOP_BITS_OUT <= 6'(UPE_LONG_EOP_BITS);
      else
        TX_EOP_BITS_OUT <= 6'(UPE_EOP_BITS);
    end
  end
endmodule
`default_nettype wire

// *** verilog/upe_skid_buf.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module upe_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem_ff [2];
  logic rd_ptr_ff;
  logic wr_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign push = in_valid_in && (count_ff != 2'h2);
  assign pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count_ff != 2'h2);
  assign out_valid_out = (count_ff != 2'h0);
  assign out_data_out = mem_ff[rd_ptr_ff];

  // Storage write
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data_in;
  end

  // Pointers and fill level
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// *** verilog/upe_status_enc.sv ***
// Combinational encoder for the receive-command status byte
`timescale 1ns/1ps
`default_nettype none
module upe_status_enc
  import upe_pkg::*;
(
  input wire logic [1:0] line_state_in,
  input wire logic sess_end_in,
  input wire logic sess_valid_in,
  input wire logic vbus_valid_in,
  input wire logic rx_active_in,
  input wire logic rx_error_in,
  input wire logic host_disc_in,
  input wire logic id_in,
  output logic [7:0] status_out
);
  logic [1:0] vbus_code;
  logic [1:0] rx_code;

  // Comparator ladder, highest threshold wins
  always_comb
  begin
    if (vbus_valid_in)
      vbus_code = UPE_VB_VALID;
    else if (sess_valid_in)
      vbus_code = UPE_VB_SESS;
    else if (sess_end_in)
      vbus_code = UPE_VB_BELOW_END;
    else
      vbus_code = UPE_VB_BETWEEN;
  end

  // Disconnect outranks receive activity
  always_comb
  begin
    if (host_disc_in)
      rx_code = UPE_RX_HOSTDISC;
    else if (rx_active_in && rx_error_in)
      rx_code = UPE_RX_ERROR;
    else if (rx_active_in)
      rx_code = UPE_RX_ACTIVE;
    else
      rx_code = UPE_RX_NONE;
  end

  // Byte assembly
  assign status_out = {UPE_STATUS_RSVD, id_in, rx_code, vbus_code, line_state_in};
endmodule
`default_nettype wire
